// *** gauge_command_regs_flags.sv ***
// command decoder, register bank and primary flag logic of the gauge
// Operation
// - command byte loads after eight received bits
// - bit 7 picks read reply or write
// - seven-bit address; bad write addresses dropped
// - flags register at 01h, fixed bit layout
// - charging flag follows charge sense pin, held low in discharge
// - pack-replaced set on sense rise with corrupt registers, or reset
// - pack-replaced held until full or empty
// - overvoltage flag follows pin, no latch
// - stale flag on 64th charge, cleared on update
// - qualified set on discharge starting full
// - qualified cleared by update, counters, cold empty
// - empty warning on low pin, rate gated
// - empty warning held until charge with recovery
// - empty warning blinks first segment at 4Hz
// - bytes travel least significant bit first
`default_nettype none
module gauge_command_regs_flags #(
    parameter int BLINK_HALF_CYCLES = gauge_pkg::BLINK_HALF_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_break,
    input wire logic i_rx_bit_valid,
    input wire logic i_rx_bit,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic o_tx_bit,
    input wire logic [gauge_pkg::PIN_COUNT-1:0] i_sense_pins,
    input wire logic i_discharge_active,
    input wire logic i_reg_corrupt,
    input wire logic i_valid_charge,
    input wire logic i_learned_update,
    input wire logic i_charge_equals_learned,
    input wire logic i_discharge_start,
    input wire logic i_self_discharge_over_limit,
    input wire logic i_charge_256,
    input wire logic i_temp_below_zero,
    input wire logic i_first_segment_display,
    input wire logic [7:0] i_temp_fuel,
    input wire logic [7:0] i_charge_high,
    input wire logic [7:0] i_charge_low,
    input wire logic [7:0] i_learned_capacity,
    input wire logic [7:0] i_secondary_flags,
    input wire logic [7:0] i_stale_count,
    input wire logic [7:0] i_full_tally,
    output logic o_write_strobe,
    output logic [6:0] o_write_addr,
    output logic [7:0] o_write_data,
    output logic o_soft_reset,
    output logic [7:0] o_primary_flags,
    output logic o_first_led_segment
);
    import gauge_pkg::*;

    link_state_t state_reg, state_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] command_reg;
    logic [7:0] tx_shift_reg;
    logic [7:0] pack_id_reg;
    logic [PIN_COUNT-1:0] sync1_reg, sync2_reg;
    logic sense_low_prev_reg;
    logic charging_flag_reg, pack_replaced_flag_reg, cell_overvoltage_flag_reg;
    logic capacity_stale_flag_reg, qualified_discharge_flag_reg;
    logic empty_warning_flag_reg;
    logic [6:0] stale_cnt_reg;
    logic [BLINK_CNT_W-1:0] blink_cnt_reg;
    logic blink_phase_reg;
    logic strobe_reg, soft_reset_reg, led_reg;
    logic [6:0] waddr_reg;
    logic [7:0] wdata_reg;

    // receive path: new bit enters at the top, so the lsb arrives first
    wire rx_take = i_ce && i_rx_bit_valid && (state_reg != ST_RDATA);
    wire rx_last = rx_take && (bit_cnt_reg == BIT_COUNT_LAST);
    wire [7:0] rx_byte = {i_rx_bit, rx_shift_reg[7:1]};
    wire cmd_load = rx_last && (state_reg == ST_CMD);
    wire data_done = rx_last && (state_reg == ST_WDATA);
    wire tx_take = i_ce && o_tx_valid && i_tx_ready;
    wire tx_last = tx_take && (bit_cnt_reg == BIT_COUNT_LAST);
    wire [6:0] cmd_addr = command_reg[6:0];
    wire [6:0] load_addr = rx_byte[6:0];

    wire addr_writable = (cmd_addr == ADDR_CHARGE_HIGH) ||
        (cmd_addr == ADDR_PACK_ID) || (cmd_addr == ADDR_LEARNED) ||
        (cmd_addr == ADDR_OVERRIDE) || (cmd_addr == ADDR_SOFT_RESET);
    wire write_go = data_done && addr_writable;
    wire soft_reset_go = write_go && (cmd_addr == ADDR_SOFT_RESET) &&
        rx_byte[BIT_SOFT_RESET];

    // flag register layout, unused bits tied low
    wire [7:0] flags_byte = {charging_flag_reg, pack_replaced_flag_reg,
        cell_overvoltage_flag_reg, capacity_stale_flag_reg,
        qualified_discharge_flag_reg, 1'b0, empty_warning_flag_reg,
        1'b0};

    // write-only and unmapped addresses outside the list return zero
    logic [7:0] read_value;
    always_comb begin
        unique case (load_addr)
            ADDR_FLAGS: read_value = flags_byte;
            ADDR_TEMP_FUEL: read_value = i_temp_fuel;
            ADDR_CHARGE_HIGH: read_value = i_charge_high;
            ADDR_PACK_ID: read_value = pack_id_reg;
            ADDR_LEARNED: read_value = i_learned_capacity;
            ADDR_SECONDARY: read_value = i_secondary_flags;
            ADDR_STALE_COUNT: read_value = i_stale_count;
            ADDR_FULL_TALLY: read_value = i_full_tally;
            ADDR_CHARGE_LOW: read_value = i_charge_low;
            default: read_value = BYTE_ZERO;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_CMD: begin
                if (cmd_load) begin
                    state_next = rx_byte[BIT_DIR] ? ST_WDATA : ST_RDATA;
                end
            end
            ST_WDATA: begin
                if (data_done) begin
                    state_next = ST_CMD;
                end
            end
            ST_RDATA: begin
                if (tx_last) begin
                    state_next = ST_CMD;
                end
            end
            default: state_next = ST_CMD;
        endcase
        // a break aborts any exchange and readies for a command
        if (i_ce && i_break) begin
            state_next = ST_CMD;
        end
    end

    assign o_tx_valid = (state_reg == ST_RDATA);
    assign o_tx_bit = tx_shift_reg[0];
    assign o_write_strobe = strobe_reg;
    assign o_write_addr = waddr_reg;
    assign o_write_data = wdata_reg;
    assign o_soft_reset = soft_reset_reg;
    assign o_primary_flags = flags_byte;
    assign o_first_led_segment = led_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= BIT_COUNT_ZERO;
            rx_shift_reg <= BYTE_ZERO;
            command_reg <= BYTE_ZERO;
            tx_shift_reg <= BYTE_ZERO;
        end else if (i_ce) begin
            state_reg <= state_next;
            if (i_break || cmd_load || data_done || tx_last) begin
                bit_cnt_reg <= BIT_COUNT_ZERO;
            end else if (rx_take || tx_take) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            if (rx_take) begin
                rx_shift_reg <= rx_byte;
            end
            if (cmd_load) begin
                command_reg <= rx_byte;
                tx_shift_reg <= read_value;
            end else if (tx_take) begin
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
        end
    end

    // write side effects, one cycle pulses
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            waddr_reg <= STALE_ZERO;
            wdata_reg <= BYTE_ZERO;
            pack_id_reg <= BYTE_ZERO;
        end else if (i_ce) begin
            strobe_reg <= write_go;
            soft_reset_reg <= soft_reset_go;
            if (write_go) begin
                waddr_reg <= cmd_addr;
                wdata_reg <= rx_byte;
            end
            if (write_go && (cmd_addr == ADDR_PACK_ID)) begin
                pack_id_reg <= rx_byte;
            end
        end
    end

    // comparator pins are asynchronous to the core clock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (i_ce) begin
            sync1_reg <= i_sense_pins;
            sync2_reg <= sync1_reg;
        end
    end

    wire sense_rise = sync2_reg[PIN_SENSE_ABOVE_0V1] && sense_low_prev_reg;
    wire empty_set = sync2_reg[PIN_SENSE_BELOW_0V90] &&
        !sync2_reg[PIN_SR_ABOVE_TH1];
    wire empty_rise = empty_set && !empty_warning_flag_reg;
    wire empty_clr = i_valid_charge &&
        !sync2_reg[PIN_SENSE_BELOW_0V90];
    wire replaced_set = (sense_rise && i_reg_corrupt) || soft_reset_go;
    wire replaced_clr = (i_valid_charge && i_charge_equals_learned) ||
        empty_rise;
    wire stale_hit = i_valid_charge &&
        (stale_cnt_reg == STALE_CHARGES - STALE_ONE);
    wire stale_room = (stale_cnt_reg != STALE_CHARGES);
    wire qual_set = i_discharge_start && i_charge_equals_learned;
    wire qual_clr = i_learned_update || i_self_discharge_over_limit ||
        i_charge_256 || (empty_rise && i_temp_below_zero);

    // every sticky flag lets its set beat a simultaneous clear
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sense_low_prev_reg <= 1'b0;
            charging_flag_reg <= 1'b0;
            pack_replaced_flag_reg <= 1'b1;
            cell_overvoltage_flag_reg <= 1'b0;
            capacity_stale_flag_reg <= 1'b1;
            qualified_discharge_flag_reg <= 1'b0;
            empty_warning_flag_reg <= 1'b0;
            stale_cnt_reg <= STALE_ZERO;
        end else if (i_ce) begin
            sense_low_prev_reg <= !sync2_reg[PIN_SENSE_ABOVE_0V1];
            charging_flag_reg <= sync2_reg[PIN_CHARGE_SENSE] &&
                !i_discharge_active;
            cell_overvoltage_flag_reg <= sync2_reg[PIN_SENSE_ABOVE_2V0];
            if (replaced_set) begin
                pack_replaced_flag_reg <= 1'b1;
            end else if (replaced_clr) begin
                pack_replaced_flag_reg <= 1'b0;
            end
            // count saturates at the threshold, no wrap
            if (stale_hit || soft_reset_go) begin
                capacity_stale_flag_reg <= 1'b1;
            end else if (i_learned_update) begin
                capacity_stale_flag_reg <= 1'b0;
            end
            if (i_learned_update) begin
                stale_cnt_reg <= STALE_ZERO;
            end else if (i_valid_charge && stale_room) begin
                stale_cnt_reg <= stale_cnt_reg + STALE_ONE;
            end
            if (qual_set) begin
                qualified_discharge_flag_reg <= 1'b1;
            end else if (qual_clr) begin
                qualified_discharge_flag_reg <= 1'b0;
            end
            if (empty_set) begin
                empty_warning_flag_reg <= 1'b1;
            end else if (empty_clr) begin
                empty_warning_flag_reg <= 1'b0;
            end
        end
    end

    // blink timer restarts so the warning starts with the segment lit
    wire blink_wrap = (blink_cnt_reg ==
        BLINK_CNT_W'(BLINK_HALF_CYCLES - 1));
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            blink_cnt_reg <= BLINK_CNT_ZERO;
            blink_phase_reg <= 1'b1;
            led_reg <= 1'b0;
        end else if (i_ce) begin
            if (!empty_warning_flag_reg || blink_wrap) begin
                blink_cnt_reg <= BLINK_CNT_ZERO;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + BLINK_CNT_ONE;
            end
            if (!empty_warning_flag_reg) begin
                blink_phase_reg <= 1'b1;
            end else if (blink_wrap) begin
                blink_phase_reg <= !blink_phase_reg;
            end
            led_reg <= empty_warning_flag_reg ? blink_phase_reg :
                i_first_segment_display;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    cmd_after_eight_a: assert property ($changed(command_reg) |->
        $past(i_ce && i_rx_bit_valid && state_reg == ST_CMD &&
        bit_cnt_reg == BIT_COUNT_LAST))
        else $error("command byte loaded early");
    dir_select_a: assert property (cmd_load && !i_break |=>
        state_reg == (command_reg[BIT_DIR] ? ST_WDATA : ST_RDATA))
        else $error("direction bit not honoured");
    write_valid_addr_a: assert property (o_write_strobe |->
        (o_write_addr == ADDR_CHARGE_HIGH || o_write_addr == ADDR_PACK_ID ||
        o_write_addr == ADDR_LEARNED || o_write_addr == ADDR_OVERRIDE ||
        o_write_addr == ADDR_SOFT_RESET))
        else $error("write to invalid address");
    unused_zero_a: assert property (o_primary_flags[2] == 1'b0 &&
        o_primary_flags[0] == 1'b0)
        else $error("unused flag bits not zero");
    charge_clear_a: assert property (i_ce && i_discharge_active |=>
        !charging_flag_reg)
        else $error("charging flag set during discharge");
    soft_reset_flag_a: assert property (o_soft_reset |->
        pack_replaced_flag_reg && capacity_stale_flag_reg)
        else $error("soft reset did not flag pack");
    overvolt_follow_a: assert property (i_ce |=>
        cell_overvoltage_flag_reg ==
        $past(sync2_reg[PIN_SENSE_ABOVE_2V0]))
        else $error("overvoltage flag not following pin");
    empty_latched_a: assert property (empty_warning_flag_reg && !empty_clr
        |=> empty_warning_flag_reg)
        else $error("empty warning dropped without charge");
    qual_set_a: assert property (i_ce && qual_set |=>
        qualified_discharge_flag_reg)
        else $error("qualified discharge not set");
    stale_set_a: assert property (i_ce && stale_hit |=>
        capacity_stale_flag_reg)
        else $error("stale flag missed 64th charge");
    led_blink_a: assert property (i_ce && !empty_warning_flag_reg |=>
        o_first_led_segment == $past(i_first_segment_display))
        else $error("segment altered without warning");

    read_seen_c: cover property (tx_last);
    write_seen_c: cover property (o_write_strobe);
    soft_reset_c: cover property (o_soft_reset);
    empty_blink_c: cover property (empty_warning_flag_reg && blink_wrap);
endmodule
`default_nettype wire

// *** gauge_command_regs_flags_tb.sv ***
// self-checking bench of the gauge command block and flags
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module gauge_command_regs_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import gauge_pkg::*;
    localparam int HALF = 4;
    localparam logic [6:0] RA [7] = '{ADDR_TEMP_FUEL, ADDR_CHARGE_HIGH,
        ADDR_CHARGE_LOW, ADDR_LEARNED, ADDR_SECONDARY, ADDR_STALE_COUNT,
        ADDR_FULL_TALLY};
    logic clk, reset_n, tx_valid, tx_bit, brk, rx_valid, rx_bit, tx_ready;
    logic [4:0] pins;
    logic ce, dis, corrupt, full_eq, sd_over, cold, seg_in, wstb, srst, led;
    logic [3:0] ev; // {charge_256, discharge_start, learned_update, charge}
    logic [7:0] rv [7];
    logic [6:0] waddr;
    logic [7:0] wdata, flags, d;
    int num_errors = 0, n_compared = 0, n_wr = 0, n_srst = 0;
    gauge_command_regs_flags #(.BLINK_HALF_CYCLES(HALF))
        gauge_command_regs_flags_inst (.i_clk(clk), .i_reset_n(reset_n),
        .i_ce(ce), .i_break(brk), .i_rx_bit_valid(rx_valid),
        .i_rx_bit(rx_bit), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_tx_bit(tx_bit), .i_sense_pins(pins), .i_discharge_active(dis),
        .i_reg_corrupt(corrupt), .i_valid_charge(ev[0]),
        .i_learned_update(ev[1]), .i_charge_equals_learned(full_eq),
        .i_discharge_start(ev[2]), .i_self_discharge_over_limit(sd_over),
        .i_charge_256(ev[3]), .i_temp_below_zero(cold),
        .i_first_segment_display(seg_in), .i_temp_fuel(rv[0]),
        .i_charge_high(rv[1]), .i_charge_low(rv[2]),
        .i_learned_capacity(rv[3]),
        .i_secondary_flags(rv[4]), .i_stale_count(rv[5]),
        .i_full_tally(rv[6]), .o_write_strobe(wstb), .o_write_addr(waddr),
        .o_write_data(wdata), .o_soft_reset(srst), .o_primary_flags(flags),
        .o_first_led_segment(led));
    gauge_host_model gauge_host_model_inst (.i_clk(clk),
        .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .o_break(brk),
        .o_rx_bit_valid(rx_valid), .o_rx_bit(rx_bit), .o_tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk) begin
        if (wstb === 1'b1) n_wr++;
        if (srst === 1'b1) n_srst++;
    end
    task automatic stop_test();
        $display("errors %0d of %0d compared", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // three edges of pin sync and flag register, plus margin
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic ev_pulse(input logic [3:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 4'h0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        gauge_host_model_inst.send_break();
        gauge_host_model_inst.send_bits({1'b1, a}, 8);
        gauge_host_model_inst.send_bits(v, 8);
        gauge_host_model_inst.release_line();
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input int stall);
        gauge_host_model_inst.send_break();
        gauge_host_model_inst.send_bits({1'b0, a}, 8);
        gauge_host_model_inst.release_line();
        gauge_host_model_inst.read_byte(stall, d);
        `CHK(tx_valid, 1'b0)
    endtask
    task automatic t_reset();
        `CHK(flags, 8'h50)
        settle();
        `CHK(led, 1'b1)
        rd(ADDR_FLAGS, 0);
        `CHK(d, 8'h50)
    endtask
    task automatic t_regs();
        wr(ADDR_PACK_ID, 8'ha5);
        `CHK(n_wr, 1)
        `CHK(waddr, ADDR_PACK_ID)
        `CHK(wdata, 8'ha5)
        wr(ADDR_TEMP_FUEL, 8'h3c);
        wr(7'h55, 8'h3c);
        wr(ADDR_LEARNED, 8'h5a);
        `CHK(n_wr, 2)
        `CHK(waddr, ADDR_LEARNED)
        rd(ADDR_PACK_ID, 2);
        `CHK(d, 8'ha5)
        // a cut-off command must leave no trace in the next one
        gauge_host_model_inst.send_break();
        gauge_host_model_inst.send_bits(8'h81, 5);
        rd(ADDR_PACK_ID, 0);
        `CHK(d, 8'ha5)
        for (int k = 0; k < 7; k++) begin
            rd(RA[k], k % 2);
            `CHK(d, rv[k])
        end
        rd(7'h7f, 0);
        `CHK(d, 8'h00)
    endtask
    task automatic t_soft();
        full_eq = 1'b1;
        ev_pulse(4'b0001);
        ev_pulse(4'b0010);
        `CHK(flags, 8'h00)
        full_eq = 1'b0;
        repeat (63) ev_pulse(4'b0001);
        `CHK(flags[FLAG_STALE], 1'b0)
        ev_pulse(4'b0001);
        `CHK(flags[FLAG_STALE], 1'b1)
        ev_pulse(4'b0010);
        `CHK(flags[FLAG_STALE], 1'b0)
        wr(ADDR_SOFT_RESET, 8'h7f);
        `CHK(n_srst, 0)
        wr(ADDR_SOFT_RESET, 8'h80);
        `CHK(n_srst, 1)
        `CHK(flags, 8'h50)
        // a frozen core must ignore a charge that would clear the flag
        ce = 1'b0;
        full_eq = 1'b1;
        ev_pulse(4'b0001);
        `CHK(flags, 8'h50)
        ce = 1'b1;
        full_eq = 1'b0;
    endtask
    task automatic t_pins();
        pins[0] = 1'b1;
        settle();
        `CHK(flags[FLAG_CHARGING], 1'b1)
        dis = 1'b1;
        settle();
        `CHK(flags[FLAG_CHARGING], 1'b0)
        dis = 1'b0;
        pins[0] = 1'b0;
        pins[2] = 1'b1;
        settle();
        `CHK(flags[FLAG_OVERVOLT], 1'b1)
        pins[2] = 1'b0;
        settle();
        `CHK(flags[FLAG_OVERVOLT], 1'b0)
        full_eq = 1'b1;
        ev_pulse(4'b0001);
        full_eq = 1'b0;
        `CHK(flags[FLAG_REPLACED], 1'b0)
        pins[1] = 1'b1;
        settle();
        `CHK(flags[FLAG_REPLACED], 1'b0)
        pins[1] = 1'b0;
        corrupt = 1'b1;
        settle();
        pins[1] = 1'b1;
        settle();
        `CHK(flags[FLAG_REPLACED], 1'b1)
        corrupt = 1'b0;
    endtask
    task automatic t_empty();
        logic prev;
        int c;
        pins[4] = 1'b1;
        pins[3] = 1'b1;
        settle();
        `CHK(flags[FLAG_EMPTY], 1'b0)
        pins[4] = 1'b0;
        seg_in = 1'b0;
        settle();
        `CHK(flags[FLAG_EMPTY], 1'b1)
        `CHK(led, 1'b1)
        `CHK(flags[FLAG_REPLACED], 1'b0)
        prev = led;
        c = 0;
        while (led === prev && c < 10) begin
            @(negedge clk);
            c++;
        end
        prev = led;
        c = 0;
        while (led === prev && c < 10) begin
            @(negedge clk);
            c++;
        end
        `CHK(c, HALF)
        ev_pulse(4'b0001);
        `CHK(flags[FLAG_EMPTY], 1'b1)
        pins[3] = 1'b0;
        settle();
        `CHK(flags[FLAG_EMPTY], 1'b1)
        ev_pulse(4'b0001);
        `CHK(flags[FLAG_EMPTY], 1'b0)
    endtask
    task automatic t_qual();
        full_eq = 1'b0;
        ev_pulse(4'b0100);
        `CHK(flags[FLAG_QUALIFIED], 1'b0)
        full_eq = 1'b1;
        for (int k = 0; k < 4; k++) begin
            ev_pulse(4'b0100);
            `CHK(flags[FLAG_QUALIFIED], 1'b1)
            case (k)
                0: ev_pulse(4'b1000);
                1: ev_pulse(4'b0010);
                2: begin
                    sd_over = 1'b1;
                    settle();
                    sd_over = 1'b0;
                end
                default: begin
                    cold = 1'b1;
                    pins[3] = 1'b1;
                    settle();
                end
            endcase
            `CHK(flags[FLAG_QUALIFIED], 1'b0)
        end
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        reset_n = 1'b0;
        pins = 5'h00;
        {ce, dis, corrupt, full_eq, sd_over, cold} = 6'h20;
        seg_in = 1'b1;
        ev = 4'h0;
        for (int k = 0; k < 7; k++) rv[k] = 8'(k * 37 + 5);
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        t_reset();
        t_regs();
        t_soft();
        t_pins();
        t_empty();
        t_qual();
        stop_test();
    end
endmodule
`default_nettype wire

// *** gauge_host_model.sv ***
// host side of the single-wire link, modelled at bit level
`default_nettype none
module gauge_host_model (
    input wire logic i_clk,
    input wire logic i_tx_valid,
    input wire logic i_tx_bit,
    output logic o_break,
    output logic o_rx_bit_valid,
    output logic o_rx_bit,
    output logic o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_break = 1'b0;
        o_rx_bit_valid = 1'b0;
        o_rx_bit = 1'b1;
        o_tx_ready = 1'b0;
    end
    task automatic send_break();
        @(negedge i_clk);
        o_rx_bit_valid = 1'b0;
        o_break = 1'b1;
        @(negedge i_clk);
        o_break = 1'b0;
        repeat (2) @(negedge i_clk); // recovery gap
    endtask
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge i_clk);
            o_rx_bit_valid = 1'b1;
            o_rx_bit = b[i];
        end
    endtask
    // idle data shows the inverse of the last bit, never a stale copy
    task automatic release_line();
        @(negedge i_clk);
        o_rx_bit_valid = 1'b0;
        o_rx_bit = ~o_rx_bit;
    endtask
    task automatic read_byte(input int stall, output logic [7:0] d);
        int w;
        w = 0;
        d = 8'h00;
        while (i_tx_valid !== 1'b1 && w < 20) begin
            @(negedge i_clk);
            w++;
        end
        for (int i = 0; i < 8; i++) begin
            if (stall > 0) begin
                o_tx_ready = 1'b0;
                repeat (stall) @(negedge i_clk);
            end
            d[i] = i_tx_bit;
            o_tx_ready = 1'b1;
            @(negedge i_clk);
        end
        o_tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** gauge_pkg.sv ***
// constants, register map and state codes of the gauge command block
`default_nettype none
package gauge_pkg;
    localparam logic [6:0] ADDR_COMMAND = 7'h00;
    localparam logic [6:0] ADDR_FLAGS = 7'h01;
    localparam logic [6:0] ADDR_TEMP_FUEL = 7'h02;
    localparam logic [6:0] ADDR_CHARGE_HIGH = 7'h03;
    localparam logic [6:0] ADDR_PACK_ID = 7'h04;
    localparam logic [6:0] ADDR_LEARNED = 7'h05;
    localparam logic [6:0] ADDR_SECONDARY = 7'h06;
    localparam logic [6:0] ADDR_STALE_COUNT = 7'h09;
    localparam logic [6:0] ADDR_OVERRIDE = 7'h0a;
    localparam logic [6:0] ADDR_FULL_TALLY = 7'h0b;
    localparam logic [6:0] ADDR_CHARGE_LOW = 7'h17;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h39;

    localparam int BIT_DIR = 7;
    localparam int BIT_SOFT_RESET = 7;
    localparam int FLAG_CHARGING = 7;
    localparam int FLAG_REPLACED = 6;
    localparam int FLAG_OVERVOLT = 5;
    localparam int FLAG_STALE = 4;
    localparam int FLAG_QUALIFIED = 3;
    localparam int FLAG_EMPTY = 1;

    // synchronised comparator pins
    localparam int PIN_CHARGE_SENSE = 0;
    localparam int PIN_SENSE_ABOVE_0V1 = 1;
    localparam int PIN_SENSE_ABOVE_2V0 = 2;
    localparam int PIN_SENSE_BELOW_0V90 = 3;
    localparam int PIN_SR_ABOVE_TH1 = 4;
    localparam int PIN_COUNT = 5;

    localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
    localparam logic [2:0] BIT_COUNT_ZERO = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] STALE_CHARGES = 7'h40;
    localparam logic [6:0] STALE_ONE = 7'h01;
    localparam logic [6:0] STALE_ZERO = 7'h00;

    localparam int CLK_HZ = 10_000_000;
    localparam int BLINK_HZ = 4;
    localparam int BLINK_HALF_DEFAULT = CLK_HZ / (2 * BLINK_HZ);
    localparam int BLINK_CNT_W = 21;
    localparam logic [20:0] BLINK_CNT_ZERO = 21'h000000;
    localparam logic [20:0] BLINK_CNT_ONE = 21'h000001;

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WDATA = 2'b01,
        ST_RDATA = 2'b10
    } link_state_t;
endpackage
`default_nettype wire
